// [rtl/psrc_pkg.sv]
package psrc_pkg;

    // Operating modes
    localparam logic [1:0] PSRC_MODE_RUN     = 2'h0;
    localparam logic [1:0] PSRC_MODE_STANDBY = 2'h1;
    localparam logic [1:0] PSRC_MODE_SLEEP   = 2'h2;

    // Register byte offsets
    localparam logic [3:0] PSRC_CTRL_OFS   = 4'h0;
    localparam logic [3:0] PSRC_MUX_OFS    = 4'h4;
    localparam logic [3:0] PSRC_BL_OFS     = 4'h8;
    localparam logic [3:0] PSRC_STATUS_OFS = 4'hC;

    // Field positions and widths in the control, mux and backlight registers
    localparam int PSRC_CTRL_AREG_BIT = 0;
    localparam int PSRC_MUX0_LSB      = 0;
    localparam int PSRC_MUX1_LSB      = 4;
    localparam int PSRC_MUX_W         = 3;
    localparam int PSRC_BL_W          = 8;

    // Values after reset
    localparam logic        PSRC_AREG_RST = 1'h0;
    localparam logic [2:0]  PSRC_MUX_RST  = 3'h0;
    localparam logic [7:0]  PSRC_BL_RST   = 8'h00;

    // Converter input selections; 0 means no supply routed
    localparam logic [2:0] PSRC_SEL_NONE   = 3'h0;
    localparam logic [2:0] PSRC_SEL_BAT    = 3'h1;
    localparam logic [2:0] PSRC_SEL_SENSOR = 3'h2;
    localparam logic [2:0] PSRC_SEL_REF    = 3'h3;
    localparam logic [2:0] PSRC_SEL_AREG   = 3'h4;

    // Start-up delay after battery good, in cycles
    localparam logic [7:0] PSRC_START_CYC = 8'h10;

    // AXI responses
    localparam logic [1:0] PSRC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] PSRC_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        PSRC_ST_POR   = 4'h1,
        PSRC_ST_START = 4'h2,
        PSRC_ST_HOLD  = 4'h4,
        PSRC_ST_RUN   = 4'h8
    } psrc_state_type;

endpackage

// [rtl/psrc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module psrc_top
    import psrc_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Supply monitors and pin, asynchronous
    input  wire logic        battery_good,
    input  wire logic        digital_supply_good,
    input  wire logic        external_reset_pin_n,
    // Operating mode, same clock
    input  wire logic [1:0]  op_mode,
    // Reset and supply outputs
    output logic             por_release,
    output logic             digital_supply_regulator_en,
    output logic             digital_reset_n,
    output logic             rtc_reset_n,
    output logic             analog_supply_regulator_en,
    output logic [2:0]       conv0_input_sel,
    output logic [2:0]       conv1_input_sel,
    output logic [7:0]       backlight_current_sink,
    // AXI4-Lite write
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    typedef struct packed {
        logic [1:0]     sync_bat;
        logic [1:0]     sync_dig;
        logic [1:0]     sync_pin;
        psrc_state_type state;
        logic [7:0]     count;
        logic [1:0]     mode_last;
        logic           por_rel;
        logic           dreg_en;
        logic           drst_n;
        logic           areg_en;
        logic [2:0]     mux0;
        logic [2:0]     mux1;
        logic [2:0]     conv0;
        logic [2:0]     conv1;
        logic [7:0]     bl;
        logic           awready;
        logic           wready;
        logic           arready;
        logic           aw_have;
        logic [3:0]     aw_addr;
        logic           w_have;
        logic [31:0]    w_data;
        logic [3:0]     w_strb;
        logic           bvalid;
        logic [1:0]     bresp;
        logic           rvalid;
        logic [1:0]     rresp;
        logic [31:0]    rdata;
    } psrc_regs_type;

    psrc_regs_type r_reg;
    psrc_regs_type r_next;

    // Stage [0] feeds only stage [1]; logic reads stage [1]
    wire logic bat_ok = r_reg.sync_bat[1];
    wire logic dig_ok = r_reg.sync_dig[1];
    wire logic pin_n  = r_reg.sync_pin[1];
    wire logic in_run = (op_mode == PSRC_MODE_RUN);

    function automatic logic [31:0] psrc_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    always_comb begin
        logic        brown_out;
        logic        pin_act;
        logic        wake_sleep;
        logic [31:0] wv;
        logic [31:0] rv;
        brown_out  = 1'b0;
        pin_act    = 1'b0;
        wake_sleep = 1'b0;
        wv         = 32'h0000_0000;
        rv         = 32'h0000_0000;
        r_next = r_reg;
        r_next.sync_bat  = {r_reg.sync_bat[0], battery_good};
        r_next.sync_dig  = {r_reg.sync_dig[0], digital_supply_good};
        r_next.sync_pin  = {r_reg.sync_pin[0], external_reset_pin_n};
        r_next.mode_last = op_mode;

        // Brown-out watch is off outside run mode
        brown_out  = in_run && (!bat_ok || !dig_ok);
        pin_act    = in_run && !pin_n;
        wake_sleep = (r_reg.mode_last == PSRC_MODE_SLEEP) && in_run;

        unique case (r_reg.state)
            PSRC_ST_POR: begin
                if (bat_ok) begin
                    r_next.state = PSRC_ST_START;
                    r_next.count = 8'h00;
                end
            end
            PSRC_ST_START: begin
                // Internal delay so no external RC is needed
                r_next.count = r_reg.count + 8'h01;
                if (!bat_ok) begin
                    r_next.state = PSRC_ST_POR;
                end else if (r_reg.count == PSRC_START_CYC) begin
                    r_next.state = PSRC_ST_HOLD;
                end
            end
            PSRC_ST_HOLD: begin
                // Pin is honoured here in any mode: no core has run yet
                if (!bat_ok) begin
                    r_next.state = PSRC_ST_POR;
                end else if (pin_n) begin
                    r_next.state = PSRC_ST_RUN;
                end
            end
            PSRC_ST_RUN: begin
                if (brown_out) begin
                    r_next.state = PSRC_ST_POR;
                end
            end
        endcase

        r_next.por_rel = (r_next.state != PSRC_ST_POR) &&
                         (r_next.state != PSRC_ST_START);
        r_next.dreg_en = r_next.por_rel;
        // Digital reset leaves the clock domain of the RTC untouched
        r_next.drst_n  = (r_next.state == PSRC_ST_RUN) && !pin_act &&
                         !wake_sleep;

        // Write channel: take address and data in either order
        if (!r_reg.aw_have && s_axi_awvalid) begin
            r_next.aw_have = 1'b1;
            r_next.aw_addr = s_axi_awaddr;
        end
        if (!r_reg.w_have && s_axi_wvalid) begin
            r_next.w_have = 1'b1;
            r_next.w_data = s_axi_wdata;
            r_next.w_strb = s_axi_wstrb;
        end
        if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid) begin
            r_next.aw_have = 1'b0;
            r_next.w_have  = 1'b0;
            r_next.bvalid  = 1'b1;
            r_next.bresp   = PSRC_RESP_OKAY;
            unique case (r_reg.aw_addr)
                PSRC_CTRL_OFS: begin
                    wv = psrc_merge({31'h0, r_reg.areg_en},
                                    r_reg.w_data, r_reg.w_strb);
                    r_next.areg_en = wv[PSRC_CTRL_AREG_BIT];
                end
                PSRC_MUX_OFS: begin
                    wv = psrc_merge({25'h0, r_reg.mux1, 1'b0, r_reg.mux0},
                                    r_reg.w_data, r_reg.w_strb);
                    r_next.mux0 = wv[PSRC_MUX0_LSB +: PSRC_MUX_W];
                    r_next.mux1 = wv[PSRC_MUX1_LSB +: PSRC_MUX_W];
                end
                PSRC_BL_OFS: begin
                    wv = psrc_merge({24'h0, r_reg.bl},
                                    r_reg.w_data, r_reg.w_strb);
                    r_next.bl = wv[PSRC_BL_W-1:0];
                end
                PSRC_STATUS_OFS: begin
                    r_next.bresp = PSRC_RESP_OKAY;
                end
                default: begin
                    r_next.bresp = PSRC_RESP_SLVERR;
                end
            endcase
        end
        if (r_reg.bvalid && s_axi_bready) begin
            r_next.bvalid = 1'b0;
        end

        // Read channel
        if (!r_reg.rvalid && s_axi_arvalid) begin
            r_next.rvalid = 1'b1;
            r_next.rresp  = PSRC_RESP_OKAY;
            unique case (s_axi_araddr)
                PSRC_CTRL_OFS:   rv = {31'h0, r_reg.areg_en};
                PSRC_MUX_OFS:    rv = {25'h0, r_reg.mux1, 1'b0, r_reg.mux0};
                PSRC_BL_OFS:     rv = {24'h0, r_reg.bl};
                PSRC_STATUS_OFS: rv = {24'h0, r_reg.state, pin_n, dig_ok,
                                       bat_ok, r_reg.drst_n};
                default: begin
                    rv = 32'h0000_0000;
                    r_next.rresp = PSRC_RESP_SLVERR;
                end
            endcase
            r_next.rdata = rv;
        end else if (r_reg.rvalid && s_axi_rready) begin
            r_next.rvalid = 1'b0;
        end

        if (!r_reg.por_rel) begin
            // Software settings return to defaults under power-up reset
            r_next.areg_en = PSRC_AREG_RST;
            r_next.mux0    = PSRC_MUX_RST;
            r_next.mux1    = PSRC_MUX_RST;
            r_next.bl      = PSRC_BL_RST;
        end

        // Registered so that no output has logic behind its flip-flop
        r_next.awready = !r_next.aw_have;
        r_next.wready  = !r_next.w_have;
        r_next.arready = !r_next.rvalid;
        // Converter routing only exists while the core is out of reset
        r_next.conv0 = r_next.drst_n ? r_next.mux0 : PSRC_SEL_NONE;
        r_next.conv1 = r_next.drst_n ? r_next.mux1 : PSRC_SEL_NONE;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r_reg <= '0;
            r_reg.state <= PSRC_ST_POR;
            r_reg.sync_pin <= 2'h3;
            r_reg.mode_last <= PSRC_MODE_RUN;
            r_reg.awready <= 1'h1;
            r_reg.wready <= 1'h1;
            r_reg.arready <= 1'h1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign por_release                 = r_reg.por_rel;
    assign digital_supply_regulator_en = r_reg.dreg_en;
    assign digital_reset_n             = r_reg.drst_n;
    assign rtc_reset_n                 = r_reg.por_rel;
    assign analog_supply_regulator_en  = r_reg.areg_en;
    assign conv0_input_sel             = r_reg.conv0;
    assign conv1_input_sel             = r_reg.conv1;
    assign backlight_current_sink      = r_reg.bl;
    assign s_axi_awready = r_reg.awready;
    assign s_axi_wready  = r_reg.wready;
    assign s_axi_bvalid  = r_reg.bvalid;
    assign s_axi_bresp   = r_reg.bresp;
    assign s_axi_arready = r_reg.arready;
    assign s_axi_rvalid  = r_reg.rvalid;
    assign s_axi_rresp   = r_reg.rresp;
    assign s_axi_rdata   = r_reg.rdata;

    a_por_hold: assert property (@(posedge aclk) disable iff (!aresetn)
        !bat_ok && r_reg.state == PSRC_ST_POR |=> !por_release)
        else $error("por released without battery good");
    a_dreg_follow: assert property (@(posedge aclk) disable iff (!aresetn)
        digital_supply_regulator_en == por_release)
        else $error("digital regulator enable differs from por release");
    a_bat_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        r_reg.state == PSRC_ST_RUN && in_run && !bat_ok
        |=> !digital_reset_n && !por_release)
        else $error("battery drop did not reset");
    a_dig_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        r_reg.state == PSRC_ST_RUN && in_run && !dig_ok
        |=> r_reg.state == PSRC_ST_POR)
        else $error("digital supply drop did not reset");
    a_sleep_nobo: assert property (@(posedge aclk) disable iff (!aresetn)
        r_reg.state == PSRC_ST_RUN && !in_run |=> por_release)
        else $error("brown-out reset outside run mode");
    a_start_delay: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(r_reg.state == PSRC_ST_START) |-> !por_release[*8])
        else $error("start-up delay too short");
    a_pin_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        in_run && !pin_n |=> !digital_reset_n)
        else $error("pin in run mode did not reset");
    a_pin_ignored: assert property (@(posedge aclk) disable iff (!aresetn)
        r_reg.state == PSRC_ST_RUN && !in_run && bat_ok &&
        r_reg.mode_last != PSRC_MODE_SLEEP |=> por_release)
        else $error("pin or mode change touched rtc reset");
    a_hold_pin: assert property (@(posedge aclk) disable iff (!aresetn)
        r_reg.state == PSRC_ST_HOLD && !pin_n |=> !digital_reset_n)
        else $error("core released while pin held");
    a_wake_reset: assert property (@(posedge aclk) disable iff (!aresetn)
        r_reg.mode_last == PSRC_MODE_SLEEP && in_run
        |=> !digital_reset_n)
        else $error("no reset on wakeup from sleep");
    a_rtc_por: assert property (@(posedge aclk) disable iff (!aresetn)
        rtc_reset_n == por_release)
        else $error("rtc reset not tied to power-up reset");

endmodule
`default_nettype wire

// [verif/psrc_supply_model.sv]
`timescale 1ns/1ps
`default_nettype none
module psrc_supply_model (
    // Commands from the bench
    input  wire logic aclk,
    input  wire logic bat_cmd,
    input  wire logic dig_cmd,
    input  wire logic pin_cmd,
    // Monitor outputs and reset pin
    output logic      battery_good,
    output logic      digital_supply_good,
    output logic      external_reset_pin_n
);
    // Pin follows pin_cmd one clock later; it is high only while the bench drives it high
    always @(posedge aclk) begin
        battery_good         <= bat_cmd;
        digital_supply_good  <= dig_cmd;
        external_reset_pin_n <= pin_cmd;
    end
endmodule
`default_nettype wire

// [verif/test_psrc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module test_psrc_top;
    import psrc_pkg::*;
    logic aclk, aresetn, bat, dig, pin, bg, dg, pn, por, dsr, drn, rtc, aen;
    logic [1:0] op_mode, bresp, rresp;
    logic [2:0] s0, s1;
    logic [7:0] bl;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata, seed, v;
    logic awv, awr, wv, wr_, bv, br, arv, arr, rv, rr;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    int err_total, cmp_count, i;

    psrc_supply_model sup (.aclk(aclk), .bat_cmd(bat), .dig_cmd(dig),
        .pin_cmd(pin), .battery_good(bg), .digital_supply_good(dg),
        .external_reset_pin_n(pn));
    psrc_top dut (.aclk(aclk), .aresetn(aresetn), .battery_good(bg),
        .digital_supply_good(dg), .external_reset_pin_n(pn),
        .op_mode(op_mode), .por_release(por),
        .digital_supply_regulator_en(dsr), .digital_reset_n(drn),
        .rtc_reset_n(rtc), .analog_supply_regulator_en(aen),
        .conv0_input_sel(s0), .conv1_input_sel(s1),
        .backlight_current_sink(bl), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wr_),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
        .s_axi_rready(rr));

    initial begin
        aclk = 1'h0;
        forever #50 aclk = ~aclk;
    end

    task automatic chk(input string n, input logic [33:0] e, logic [33:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic axw(input logic [3:0] a, logic [31:0] d, logic [1:0] e);
        @(posedge aclk);
        awaddr <= a;
        wdata  <= d;
        awv    <= 1'h1;
        wv     <= 1'h1;
        br     <= 1'h1;
        bq.push_back(e);
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'h0;
            if (wr_) wv <= 1'h0;
        end while (!bv);
        br <= 1'h0;
    endtask

    task automatic axr(input logic [3:0] a, logic [31:0] d, logic [1:0] e);
        @(posedge aclk);
        araddr <= a;
        arv    <= 1'h1;
        rr     <= 1'h1;
        rq.push_back({e, d});
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'h0;
        end while (!rv);
        rr <= 1'h0;
    endtask

    // Scoreboard: responses are judged where they appear on the bus
    always @(posedge aclk) begin
        if (bv && br) chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bresp});
        if (rv && rr) chk("rdata", rq.pop_front(), {rresp, rdata});
    end

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        cyc(20000);
        err_total++;
        print_verdict();
    end

    initial begin
        {aresetn, bat, awv, wv, br, arv, rr} = 7'h00;
        {dig, pin} = 2'h3;
        op_mode = PSRC_MODE_RUN;
        {awaddr, araddr, wstrb, wdata} = {8'h00, 4'hF, 32'h0};
        seed = 32'he07f;
        cyc(16);
        aresetn <= 1'h1;
        cyc(30);
        chk("por_low", 34'h0, {33'h0, por});
        bat <= 1'h1;
        for (i = 0; i < 100 && !drn; i++) cyc(1);
        chk("por", 34'h3, {32'h0, por, rtc});
        chk("dsr_en", 34'h1, {33'h0, dsr});
        axr(PSRC_STATUS_OFS, 32'h8F, PSRC_RESP_OKAY);
        $display("Test power-up done");
        axw(PSRC_CTRL_OFS, 32'h1, PSRC_RESP_OKAY);
        chk("areg_en", 34'h1, {33'h0, aen});
        for (int k = 0; k < 3; k++) begin
            v = {25'h0, 3'(($unsigned($random(seed))) % 5), 1'h0,
                 3'(($unsigned($random(seed))) % 5)};
            axw(PSRC_MUX_OFS, v, PSRC_RESP_OKAY);
            chk("sel", {28'h0, v[6:4], v[2:0]}, {28'h0, s1, s0});
            axr(PSRC_MUX_OFS, v, PSRC_RESP_OKAY);
        end
        v = {24'h0, 8'($random(seed))};
        axw(PSRC_BL_OFS, v, PSRC_RESP_OKAY);
        chk("bl", {26'h0, v[7:0]}, {26'h0, bl});
        // Lane 0 strobe off: the level must not move
        wstrb <= 4'hE;
        axw(PSRC_BL_OFS, ~v, PSRC_RESP_OKAY);
        wstrb <= 4'hF;
        chk("bl_strb", {26'h0, v[7:0]}, {26'h0, bl});
        axw(4'h6, 32'hFF, PSRC_RESP_SLVERR);
        chk("bl_unmap", {26'h0, v[7:0]}, {26'h0, bl});
        axw(PSRC_STATUS_OFS, 32'h0, PSRC_RESP_OKAY);
        axr(4'h6, 32'h0, PSRC_RESP_SLVERR);
        $display("Test registers done");
        pin <= 1'h0;
        cyc(8);
        chk("pin_rst", 34'h3, {32'h0, drn, rtc, por});
        chk("sel_rst", 34'h0, {28'h0, s1, s0});
        pin <= 1'h1;
        for (i = 0; i < 50 && !drn; i++) cyc(1);
        chk("pin_rel", 34'h1, {33'h0, drn});
        $display("Test pin run done");
        for (int m = 1; m < 3; m++) begin
            op_mode <= 2'(m);
            {pin, bat, dig} <= 3'h0;
            cyc(20);
            chk("lowpow", 34'h7, {32'h0, drn, por, rtc});
            {pin, bat, dig} <= 3'h7;
            cyc(6);
        end
        op_mode <= PSRC_MODE_SLEEP;
        cyc(4);
        op_mode <= PSRC_MODE_RUN;
        v = 32'h0;
        for (i = 0; i < 5; i++) begin
            cyc(1);
            if (!drn) v = 32'h1;
        end
        chk("wake", 34'h1, {2'h0, v});
        $display("Test modes done");
        for (i = 0; i < 50 && !drn; i++) cyc(1);
        dig <= 1'h0;
        cyc(8);
        chk("dig_bo", 34'h0, {33'h0, drn});
        dig <= 1'h1;
        for (i = 0; i < 100 && !drn; i++) cyc(1);
        bat <= 1'h0;
        cyc(8);
        chk("bat_bo", 34'h0, {31'h0, por, dsr, aen});
        pin <= 1'h0;
        bat <= 1'h1;
        cyc(60);
        chk("pin_hold", 34'h2, {32'h0, por, drn});
        pin <= 1'h1;
        for (i = 0; i < 50 && !drn; i++) cyc(1);
        chk("pin_free", 34'h1, {33'h0, drn});
        $display("Test brown-out done");
        print_verdict();
    end
endmodule
`default_nettype wire
